// *** common/fdcs_pkg.sv ***
/*
  Constants, register map and types of the clock system block.
  Assumes one APB clock domain; every other file except the oscillator model imports this package.
*/
package fdcs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned TAP_W  = 5;
  localparam int unsigned MIX_W  = 5;
  localparam int unsigned TGT_W  = 10;
  localparam int unsigned SEL_W  = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] FLL_CTRL_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] CLK_SEL_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] OSC_CTRL_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] OSC_FAULT_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] OSC_TUNE_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 8'h1C;

  // Field positions
  localparam int unsigned FLL_EN_BIT     = 0;
  localparam int unsigned REF_SEL_BIT    = 1;
  localparam int unsigned TARGET_LSB     = 16;
  localparam int unsigned AUX_SEL_LSB    = 0;
  localparam int unsigned SUB_SEL_LSB    = 4;
  localparam int unsigned MAIN_SEL_LSB   = 8;
  localparam int unsigned BYPASS_BIT     = 0;
  localparam int unsigned XT1_ON_BIT     = 1;
  localparam int unsigned XT2_ON_BIT     = 2;
  localparam int unsigned FAULT_NMI_BIT  = 3;
  localparam int unsigned FAULT_ANY_BIT  = 3;
  localparam int unsigned TAP_LSB        = 8;
  localparam int unsigned NUM_FAULTS     = 3;
  localparam int unsigned NUM_IRQ        = 3;
  localparam int unsigned IRQ_FAULT_BIT  = 0;
  localparam int unsigned IRQ_LOCK_BIT   = 1;
  localparam int unsigned IRQ_LIMIT_BIT  = 2;

  // Values after reset
  localparam logic [TAP_W-1:0] TAP_RST    = 5'h0C;
  localparam logic [MIX_W-1:0] MIX_RST    = 5'h00;
  localparam logic [TGT_W-1:0] TARGET_RST = 10'h020;
  localparam logic [SEL_W-1:0] MAIN_RST   = 3'h3;
  localparam logic [SEL_W-1:0] SUB_RST    = 3'h4;
  localparam logic [SEL_W-1:0] AUX_RST    = 3'h0;
  localparam logic [MIX_W-1:0] MIX_MAX    = 5'h1F;

  // Low power levels as reported by the core
  localparam logic [2:0] LP_LEVEL_THREE = 3'h3;
  localparam logic [2:0] LP_LEVEL_FOUR  = 3'h4;

  // Settling span in reference periods
  localparam int unsigned LOCK_SIDE        = 32;
  localparam int unsigned LOCK_REF_PERIODS = LOCK_SIDE * LOCK_SIDE;
  localparam int unsigned LOCK_CNT_W       = 11;

  // Synchronised pin indices
  localparam int unsigned NUM_PINS   = 5;
  localparam int unsigned PIN_REFINT = 0;
  localparam int unsigned PIN_REFXT  = 1;
  localparam int unsigned PIN_DCO    = 2;
  localparam int unsigned PIN_XT1F   = 3;
  localparam int unsigned PIN_XT2F   = 4;

  typedef enum logic [1:0] {
    FLL_WAIT    = 2'b00,
    FLL_MEASURE = 2'b01,
    FLL_APPLY   = 2'b10
  } fdcs_fll_state_t;

endpackage : fdcs_pkg

// *** rtl/fdcs_modulator.sv ***
/*
  Tap dither modulator: mixes the coarse tap with the next higher tap.
  Assumes tap and mix come from flip-flops in the same clock domain.
*/
`timescale 1ns/10ps
module fdcs_modulator
  import fdcs_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [TAP_W-1:0] tap,
  input  wire logic [MIX_W-1:0] mix,
  output logic      [TAP_W-1:0] tap_out_q
);

  logic [MIX_W-1:0] phase_q;
  logic             use_upper;

  // Mix of 32-cycle frame spent on the upper tap
  assign use_upper = (phase_q < mix) && (tap != {TAP_W{1'b1}});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_q <= '0;
    else if (ce)
      phase_q <= phase_q + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tap_out_q <= TAP_RST;
    else if (ce)
      tap_out_q <= use_upper ? tap + 1'b1 : tap;
  end

endmodule : fdcs_modulator

// *** rtl/fdcs_clock_system.sv ***
/*
  Clock system: frequency-locked loop, clock source selects, oscillator
  faults, bypass and peripheral clock requests, behind an APB slave.
  Assumes reference, oscillator pulse and fault pins are asynchronous.
*/
// Function
// - Loop counts oscillator pulses between two rising reference edges.
// - A correction spans capture over one period, then one period to apply.
// - Modulator dithers between coarse tap and next higher tap.
// - Fraction rolls over from 31 into the next tap, never skips.
// - Loop stops when generator-off is set, resumes in interrupt or active.
// - Source selects switch clocks without raising any oscillator fault.
// - Combined fault with its enable requests a non-maskable interrupt.
// - Serial source clock is requested only while a transfer runs.
// - Bypass cleared lets deepest low-power level reach low current.
`timescale 1ns/10ps
module fdcs_clock_system
  import fdcs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ref_int_pin,
  input  wire logic              ref_xt_pin,
  input  wire logic              dco_pulse_pin,
  input  wire logic              xt1_fault_pin,
  input  wire logic              xt2_fault_pin,
  input  wire logic              sysclk_gen_off_bit,
  input  wire logic              isr_active,
  input  wire logic [2:0]        lp_level,
  input  wire logic              serial_soft_reset,
  input  wire logic              serial_busy,
  output logic      [TAP_W-1:0]  osc_tap_out,
  output logic      [SEL_W-1:0]  main_clk_source_sel,
  output logic      [SEL_W-1:0]  sub_clk_source_sel,
  output logic      [SEL_W-1:0]  aux_clk_source_sel,
  output logic                   crystal_one_bypass,
  output logic                   serial_clk_req,
  output logic                   low_current_ok,
  output logic                   nmi_req,
  output logic                   irq
);

  localparam logic [LOCK_CNT_W-1:0] LOCK_DONE = LOCK_CNT_W'(LOCK_REF_PERIODS);
  localparam int unsigned TM_W = TAP_W + MIX_W;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // Pin synchronisers
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] sync_meta_q;
  logic [NUM_PINS-1:0] sync_q;
  logic [NUM_PINS-1:0] sync_prev_q;

  assign pin_raw = {xt2_fault_pin, xt1_fault_pin, dco_pulse_pin, ref_xt_pin, ref_int_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_meta_q[gi] <= 1'b0;
          sync_q[gi]      <= 1'b0;
          sync_prev_q[gi] <= 1'b0;
        end
        else if (ce)
        begin
          sync_meta_q[gi] <= pin_raw[gi];
          sync_q[gi]      <= sync_meta_q[gi];
          sync_prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  // Control registers
  logic             fll_en_q;
  logic             ref_sel_q;
  logic [TGT_W-1:0] target_q;
  logic [SEL_W-1:0] main_sel_q;
  logic [SEL_W-1:0] sub_sel_q;
  logic [SEL_W-1:0] aux_sel_q;
  logic             bypass_q;
  logic             xt1_on_q;
  logic             xt2_on_q;
  logic             fault_nmi_en_q;
  logic [NUM_IRQ-1:0]    irq_mask_q;
  logic [NUM_IRQ-1:0]    irq_stat_q;
  logic [NUM_FAULTS-1:0] fault_q;
  logic [TM_W-1:0]       tapmix_q;

  // APB handshake: one wait state, answer from flip-flops
  logic access;
  logic wr_fire;
  logic rd_take;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign access  = psel & penable;
  assign wr_fire = access & pready & pwrite;
  assign rd_take = access & ~pready;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= IRQ_MASK_OFS);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (ce)
    begin
      pready  <= rd_take;
      pslverr <= rd_take & ~addr_ok;
      if (rd_take && !pwrite)
        prdata <= addr_ok ? rd_mux : 32'h0000_0000;
    end
  end

  // Loop control and reference selection
  logic fll_run;
  logic ref_rise;
  logic dco_rise;

  assign fll_run  = fll_en_q & (~sysclk_gen_off_bit | isr_active);
  assign ref_rise = ref_sel_q ? (sync_q[PIN_REFXT] & ~sync_prev_q[PIN_REFXT])
                              : (sync_q[PIN_REFINT] & ~sync_prev_q[PIN_REFINT]);
  assign dco_rise = sync_q[PIN_DCO] & ~sync_prev_q[PIN_DCO];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fll_en_q  <= 1'b1;
      ref_sel_q <= 1'b0;
      target_q  <= TARGET_RST;
    end
    else if (ce && wr_fire && reg_hit(paddr, FLL_CTRL_OFS))
    begin
      fll_en_q  <= pwdata[FLL_EN_BIT];
      ref_sel_q <= pwdata[REF_SEL_BIT];
      target_q  <= pwdata[TARGET_LSB +: TGT_W];
    end
  end

  // Clock source selects; faults are left alone on purpose
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_sel_q <= MAIN_RST;
      sub_sel_q  <= SUB_RST;
      aux_sel_q  <= AUX_RST;
    end
    else if (ce && wr_fire && reg_hit(paddr, CLK_SEL_OFS))
    begin
      main_sel_q <= pwdata[MAIN_SEL_LSB +: SEL_W];
      sub_sel_q  <= pwdata[SUB_SEL_LSB +: SEL_W];
      aux_sel_q  <= pwdata[AUX_SEL_LSB +: SEL_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bypass_q       <= 1'b0;
      xt1_on_q       <= 1'b0;
      xt2_on_q       <= 1'b0;
      fault_nmi_en_q <= 1'b0;
    end
    else if (ce && wr_fire && reg_hit(paddr, OSC_CTRL_OFS))
    begin
      bypass_q       <= pwdata[BYPASS_BIT];
      xt1_on_q       <= pwdata[XT1_ON_BIT];
      xt2_on_q       <= pwdata[XT2_ON_BIT];
      fault_nmi_en_q <= pwdata[FAULT_NMI_BIT];
    end
  end

  // Frequency-locked loop sequencer
  fdcs_fll_state_t fll_state_q;
  logic [TGT_W-1:0] dco_cnt_q;
  logic [TGT_W-1:0] meas_q;
  logic             apply_evt;
  logic             limit_evt;
  logic             go_up;
  logic             go_down;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fll_state_q <= FLL_WAIT;
      dco_cnt_q   <= '0;
      meas_q      <= '0;
    end
    else if (ce)
    begin
      if (!fll_run)
      begin
        // Partial measurements are dropped so a short run cannot drift
        fll_state_q <= FLL_WAIT;
        dco_cnt_q   <= '0;
      end
      else
      begin
        unique case (fll_state_q)
          FLL_WAIT:
            if (ref_rise)
            begin
              fll_state_q <= FLL_MEASURE;
              dco_cnt_q   <= '0;
            end
          FLL_MEASURE:
            if (ref_rise)
            begin
              fll_state_q <= FLL_APPLY;
              meas_q      <= dco_cnt_q;
            end
            else if (dco_rise && dco_cnt_q != {TGT_W{1'b1}})
              dco_cnt_q <= dco_cnt_q + 1'b1;
          FLL_APPLY:
            if (ref_rise)
              fll_state_q <= FLL_WAIT;
          default:
            fll_state_q <= FLL_WAIT;
        endcase
      end
    end
  end

  assign apply_evt = fll_run && (fll_state_q == FLL_APPLY) && ref_rise;
  assign go_up     = apply_evt && (meas_q < target_q);
  assign go_down   = apply_evt && (meas_q > target_q);
  assign limit_evt = (go_up && tapmix_q == {TM_W{1'b1}}) || (go_down && tapmix_q == '0);

  // Tap and fraction held as one number so carries pass cleanly
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tapmix_q <= {TAP_RST, MIX_RST};
    else if (ce)
    begin
      if (wr_fire && reg_hit(paddr, OSC_TUNE_OFS))
        tapmix_q <= {pwdata[TAP_LSB +: TAP_W], pwdata[MIX_W-1:0]};
      else if (go_up && tapmix_q != {TM_W{1'b1}})
        tapmix_q <= tapmix_q + 1'b1;
      else if (go_down && tapmix_q != '0)
        tapmix_q <= tapmix_q - 1'b1;
    end
  end

  fdcs_modulator u_modulator (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .tap       (tapmix_q[TM_W-1:MIX_W]),
    .mix       (tapmix_q[MIX_W-1:0]),
    .tap_out_q (osc_tap_out)
  );

  // Settling counter; status and lock interrupt only, software still owns the wait
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic                  locked;
  logic                  lock_evt;

  assign locked   = (lock_cnt_q == LOCK_DONE);
  assign lock_evt = fll_run && ref_rise && (lock_cnt_q == LOCK_DONE - 1'b1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_cnt_q <= '0;
    else if (ce)
    begin
      if (!fll_en_q)
        lock_cnt_q <= '0;
      else if (fll_run && ref_rise && !locked)
        lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // Oscillator fault flags: crystal faults count only when configured; the loop limit also faults
  logic [NUM_FAULTS-1:0] fault_set;
  logic [NUM_FAULTS-1:0] fault_clr;
  logic                  osc_fault_flag;

  assign fault_set = {limit_evt, sync_q[PIN_XT2F] & xt2_on_q, sync_q[PIN_XT1F] & xt1_on_q};
  assign fault_clr = (wr_fire && reg_hit(paddr, OSC_FAULT_OFS)) ? pwdata[NUM_FAULTS-1:0] : '0;
  assign osc_fault_flag = |fault_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_q <= '0;
    else if (ce)
      fault_q <= (fault_q & ~fault_clr) | fault_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_req <= 1'b0;
    else if (ce)
      nmi_req <= osc_fault_flag & fault_nmi_en_q;
  end

  // Interrupt status, mask and output
  logic [NUM_IRQ-1:0] irq_set;
  logic [NUM_IRQ-1:0] irq_clr;

  assign irq_set = {limit_evt, lock_evt, |(fault_set & ~fault_q)};
  assign irq_clr = (wr_fire && reg_hit(paddr, IRQ_STAT_OFS)) ? pwdata[NUM_IRQ-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= '0;
    else if (ce)
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= '0;
    else if (ce && wr_fire && reg_hit(paddr, IRQ_MASK_OFS))
      irq_mask_q <= pwdata[NUM_IRQ-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // Clock selects, bypass and power hints out to the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_clk_source_sel <= MAIN_RST;
      sub_clk_source_sel  <= SUB_RST;
      aux_clk_source_sel  <= AUX_RST;
      crystal_one_bypass  <= 1'b0;
      serial_clk_req      <= 1'b0;
      low_current_ok      <= 1'b0;
    end
    else if (ce)
    begin
      main_clk_source_sel <= main_sel_q;
      sub_clk_source_sel  <= sub_sel_q;
      aux_clk_source_sel  <= aux_sel_q;
      crystal_one_bypass  <= bypass_q;
      // Idle serial port out of soft reset must not hold its source on
      serial_clk_req      <= ~serial_soft_reset & serial_busy;
      low_current_ok      <= (lp_level == LP_LEVEL_FOUR) && !bypass_q;
    end
  end

  // Read data
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      FLL_CTRL_OFS:
      begin
        rd_mux[FLL_EN_BIT]            = fll_en_q;
        rd_mux[REF_SEL_BIT]           = ref_sel_q;
        rd_mux[TARGET_LSB +: TGT_W]   = target_q;
      end
      CLK_SEL_OFS:
      begin
        rd_mux[MAIN_SEL_LSB +: SEL_W] = main_sel_q;
        rd_mux[SUB_SEL_LSB +: SEL_W]  = sub_sel_q;
        rd_mux[AUX_SEL_LSB +: SEL_W]  = aux_sel_q;
      end
      OSC_CTRL_OFS:
      begin
        rd_mux[BYPASS_BIT]    = bypass_q;
        rd_mux[XT1_ON_BIT]    = xt1_on_q;
        rd_mux[XT2_ON_BIT]    = xt2_on_q;
        rd_mux[FAULT_NMI_BIT] = fault_nmi_en_q;
      end
      OSC_FAULT_OFS:
      begin
        rd_mux[NUM_FAULTS-1:0] = fault_q;
        rd_mux[FAULT_ANY_BIT]  = osc_fault_flag;
      end
      OSC_TUNE_OFS:
      begin
        rd_mux[MIX_W-1:0]         = tapmix_q[MIX_W-1:0];
        rd_mux[TAP_LSB +: TAP_W]  = tapmix_q[TM_W-1:MIX_W];
      end
      STATUS_OFS:
        rd_mux[3:0] = {serial_clk_req, low_current_ok, fll_run, locked};
      IRQ_STAT_OFS:
        rd_mux[NUM_IRQ-1:0] = irq_stat_q;
      IRQ_MASK_OFS:
        rd_mux[NUM_IRQ-1:0] = irq_mask_q;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

endmodule : fdcs_clock_system

// *** verif/fdcs_clock_system_checker.sv ***
/*
  Port assertions for the clock system block.
  Assumes one pclk domain and is bound to the top module below.
*/
`timescale 1ns/10ps
module fdcs_clock_system_checker
  import fdcs_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [2:0]        lp_level,
  input wire logic              serial_soft_reset,
  input wire logic              serial_busy,
  input wire logic [SEL_W-1:0]  main_clk_source_sel,
  input wire logic [SEL_W-1:0]  sub_clk_source_sel,
  input wire logic [SEL_W-1:0]  aux_clk_source_sel,
  input wire logic              crystal_one_bypass,
  input wire logic              serial_clk_req,
  input wire logic              low_current_ok
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_sel;
  logic wr_osc;
  assign acc    = psel && penable && pready;
  assign wr_sel = acc && pwrite && paddr == CLK_SEL_OFS;
  assign wr_osc = acc && pwrite && paddr == OSC_CTRL_OFS;
  serial_req_a: assert property ($past(presetn) && $past(ce) |->
    serial_clk_req == $past(!serial_soft_reset && serial_busy))
    else $error("serial clock request wrong");
  // Bypass pin and low-current flag both lag the bypass register by one cycle
  low_cur_a: assert property ($past(presetn) && $past(ce) |->
    low_current_ok == ($past(lp_level == LP_LEVEL_FOUR) && !crystal_one_bypass))
    else $error("low current flag wrong");
  sel_hold_a: assert property (
    $changed({main_clk_source_sel, sub_clk_source_sel, aux_clk_source_sel})
    |-> $past(wr_sel) || $past(wr_sel, 2)) else $error("select moved unasked");
  bypass_hold_a: assert property ($changed(crystal_one_bypass) |->
    $past(wr_osc) || $past(wr_osc, 2)) else $error("bypass moved unasked");
  ready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
  no_early_a: assert property (psel && !penable |=> !pready)
    else $error("ready without wait state");
  one_wait_a: assert property (psel && !penable && ce ##1 ce |=> pready)
    else $error("ready late");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  refuse_a: assert property (acc |->
    pslverr == (paddr[1:0] != 2'h0 || paddr > IRQ_MASK_OFS))
    else $error("error response wrong");
  cover property (wr_sel);
  cover property (acc && pslverr);
  cover property ($rose(low_current_ok));
  cover property ($rose(serial_clk_req));
endmodule : fdcs_clock_system_checker

bind fdcs_clock_system fdcs_clock_system_checker u_chk (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .lp_level, .serial_soft_reset,
  .serial_busy, .main_clk_source_sel, .sub_clk_source_sel, .aux_clk_source_sel,
  .crystal_one_bypass, .serial_clk_req, .low_current_ok);

// *** verif/fdcs_osc_model.sv ***
/*
  Far-side sources: reference oscillators, oscillator pulse train, faults.
  Assumes the bench sets the pulse half period, never faster than pclk/4.
*/
`timescale 1ns/10ps
module fdcs_osc_model
#(
  parameter int REF_HALF = 3200
)
(
  output logic             ref_int_pin,
  output logic             ref_xt_pin,
  output logic             dco_pulse_pin,
  output logic             xt1_fault_pin,
  output logic             xt2_fault_pin,
  input  wire logic [15:0] dco_half,
  input  wire logic        xt1_bad,
  input  wire logic        xt2_bad
);
  initial
  begin
    ref_int_pin = 1'h0;
    forever #(REF_HALF) ref_int_pin = ~ref_int_pin;
  end
  // Crystal reference offset in phase, so edges never align
  initial
  begin
    ref_xt_pin = 1'h0;
    #(REF_HALF / 3);
    forever #(REF_HALF) ref_xt_pin = ~ref_xt_pin;
  end
  // Plus one keeps a zero setting from hanging time
  initial
  begin
    dco_pulse_pin = 1'h0;
    forever #(dco_half + 16'h1) dco_pulse_pin = ~dco_pulse_pin;
  end
  assign xt1_fault_pin = xt1_bad;
  assign xt2_fault_pin = xt2_bad;
endmodule : fdcs_osc_model

// *** verif/fdcs_clock_system_bench.sv ***
/*
  Self-checking bench of the clock system, register access over APB.
  Assumes the checker is bound and the oscillator model feeds the pins.
*/
`timescale 1ns/10ps
module fdcs_clock_system_bench
  import fdcs_pkg::*;
;
  typedef struct {
    logic srst, busy;
    logic [2:0] lp;
    logic byp;
    logic [10:0] sel;
    logic req, lc;
  } fdcs_row_t;
  localparam logic [31:0] FCTL = 32'(TARGET_RST) << TARGET_LSB;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sysclk_gen_off_bit, isr_active, serial_soft_reset, serial_busy;
  logic [2:0]  lp_level, main_clk_source_sel, sub_clk_source_sel, aux_clk_source_sel;
  logic [4:0]  osc_tap_out;
  logic        crystal_one_bypass, serial_clk_req, low_current_ok, nmi_req, irq, er;
  logic        ref_int_pin, ref_xt_pin, dco_pulse_pin, xt1_fault_pin, xt2_fault_pin;
  logic [15:0] dco_half;
  logic        xt1_bad, xt2_bad;
  int          err_total, n_compared, n, m;
  fdcs_row_t   rows [5] = '{
    '{1'h1, 1'h1, 3'h4, 1'h0, 11'h000, 1'h0, 1'h1},
    '{1'h0, 1'h1, 3'h4, 1'h1, 11'h111, 1'h1, 1'h0},
    '{1'h0, 1'h0, 3'h3, 1'h0, 11'h234, 1'h0, 1'h0},
    '{1'h0, 1'h1, 3'h0, 1'h0, 11'h765, 1'h1, 1'h0},
    '{1'h1, 1'h0, 3'h4, 1'h0, 11'h502, 1'h0, 1'h1}};

  fdcs_clock_system DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ref_int_pin, .ref_xt_pin, .dco_pulse_pin, .xt1_fault_pin,
    .xt2_fault_pin, .sysclk_gen_off_bit, .isr_active, .lp_level, .serial_soft_reset,
    .serial_busy, .osc_tap_out, .main_clk_source_sel, .sub_clk_source_sel,
    .aux_clk_source_sel, .crystal_one_bypass, .serial_clk_req, .low_current_ok,
    .nmi_req, .irq);
  fdcs_osc_model u_osc (.ref_int_pin, .ref_xt_pin, .dco_pulse_pin, .xt1_fault_pin,
    .xt2_fault_pin, .dco_half, .xt1_bad, .xt2_bad);

  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    if (k >= 50)
    begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask : apb

  // Bounded poll of the tune word until the loop moves it
  task automatic poll(input logic [31:0] from, input logic [31:0] e);
    int k;
    k = 0;
    do
    begin
      apb(1'h0, OSC_TUNE_OFS, 32'h0);
      k++;
    end
    while (rd === from && k < 300);
    chk(rd, e);
    if (k >= 300)
      summarize();
  endtask : poll

  // Just under two reference periods (300 cycles) pass with no step; a step follows later
  task automatic corr(input logic [31:0] t, input logic [15:0] h, input logic [31:0] e,
                      input logic [31:0] c);
    apb(1'h1, FLL_CTRL_OFS, FCTL);
    apb(1'h1, OSC_TUNE_OFS, t);
    dco_half <= h;
    apb(1'h1, FLL_CTRL_OFS, FCTL | c);
    repeat (300) @(posedge pclk);
    apb(1'h0, OSC_TUNE_OFS, 32'h0);
    chk(rd, t);
    poll(t, e);
  endtask : corr

  initial
  begin
    {presetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    {sysclk_gen_off_bit, isr_active, lp_level, serial_soft_reset, serial_busy} = '0;
    {xt1_bad, xt2_bad, err_total, n_compared} = '0;
    dco_half = 16'h0064;
    ce = 1'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(32'(osc_tap_out), 32'(TAP_RST));
    chk(32'({main_clk_source_sel, sub_clk_source_sel, aux_clk_source_sel}),
        32'({MAIN_RST, SUB_RST, AUX_RST}));
    apb(1'h0, FLL_CTRL_OFS, 32'h0);
    chk(rd, FCTL | 32'h1);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk(rd, 32'h2);
    apb(1'h0, OSC_TUNE_OFS, 32'h0);
    chk(rd, 32'(TAP_RST) << TAP_LSB | 32'(MIX_RST));
    apb(1'h0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'h1, 8'h06, 32'hFFFF_FFFF);
    chk(32'(er), 32'h1);
    // Absent crystals report no faults while every source moves
    {xt1_bad, xt2_bad} <= 2'h3;
    foreach (rows[i])
    begin
      serial_soft_reset <= rows[i].srst;
      serial_busy       <= rows[i].busy;
      lp_level          <= rows[i].lp;
      apb(1'h1, OSC_CTRL_OFS, 32'(rows[i].byp));
      apb(1'h1, CLK_SEL_OFS, 32'(rows[i].sel));
      repeat (2) @(posedge pclk);
      chk(32'({serial_clk_req, low_current_ok}), 32'({rows[i].req, rows[i].lc}));
      chk(32'({1'h0, main_clk_source_sel, 1'h0, sub_clk_source_sel, 1'h0,
          aux_clk_source_sel}), 32'(rows[i].sel));
      apb(1'h0, CLK_SEL_OFS, 32'h0);
      chk(rd, 32'(rows[i].sel));
    end
    apb(1'h0, OSC_FAULT_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, OSC_CTRL_OFS, 32'h0000_000A);
    repeat (6) @(posedge pclk);
    chk(32'(nmi_req), 32'h1);
    apb(1'h0, OSC_FAULT_OFS, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'h0, IRQ_STAT_OFS, 32'h0);
    chk({rd[30:0], irq}, 32'h2);
    apb(1'h1, IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    xt1_bad <= 1'h0;
    repeat (4) @(posedge pclk);
    apb(1'h1, OSC_FAULT_OFS, 32'h1);
    apb(1'h1, IRQ_STAT_OFS, 32'h1);
    apb(1'h0, OSC_FAULT_OFS, 32'h0);
    chk({rd[29:0], nmi_req, irq}, 32'h0);
    // Crystal reference first; last run must leave the oscillator slow
    corr(32'h0000_0A10, 16'h0050, 32'h0000_0A0F, 32'h3);
    corr(32'h0000_0C00, 16'h0050, 32'h0000_0B1F, 32'h1);
    corr(32'h0000_051F, 16'h0078, 32'h0000_0600, 32'h1);
    sysclk_gen_off_bit <= 1'h1;
    apb(1'h1, OSC_TUNE_OFS, 32'h0000_0C00);
    repeat (800) @(posedge pclk);
    apb(1'h0, OSC_TUNE_OFS, 32'h0);
    chk(rd, 32'h0000_0C00);
    isr_active <= 1'h1;
    poll(32'h0000_0C00, 32'h0000_0C01);
    apb(1'h1, FLL_CTRL_OFS, FCTL);
    apb(1'h1, OSC_TUNE_OFS, 32'h0000_0508);
    repeat (64) @(posedge pclk);
    {n, m} = '0;
    repeat (32)
    begin
      @(posedge pclk);
      n += int'(osc_tap_out === 5'h06);
      m += int'(osc_tap_out === 5'h05);
    end
    chk(32'(n), 32'h8);
    chk(32'(m), 32'h18);
    // Clock enable low must freeze the dither
    ce <= 1'h0;
    @(posedge pclk);
    n = int'(osc_tap_out);
    repeat (40) @(posedge pclk);
    chk(32'(osc_tap_out), 32'(n));
    // Mid-run reset restores the defaults
    {ce, presetn} <= 2'h2;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(32'(osc_tap_out), 32'(TAP_RST));
    apb(1'h0, OSC_TUNE_OFS, 32'h0);
    chk(rd, 32'(TAP_RST) << TAP_LSB);
    summarize();
  end
endmodule : fdcs_clock_system_bench
